// *** design/uart_dp_params.svh ***
`ifndef UART_DP_PARAMS_SVH
`define UART_DP_PARAMS_SVH
// register byte offsets
`define OFS_RX_LOW   12'h000
`define OFS_RX_HIGH  12'h004
`define OFS_TX_LOW   12'h008
`define OFS_TX_HIGH  12'h00c
`define OFS_STATUS   12'h010
`define OFS_CTRL_A   12'h014
`define OFS_CTRL_B   12'h018
`define OFS_CTRL_C   12'h01c
`define OFS_BAUD     12'h020
// high byte, status and control field positions
`define POS_DATA8    0
`define POS_PARITY_FAULT_FLAG     1
`define POS_OVF      2
`define POS_FRAMING_FAULT_FLAG     3
`define POS_RXDONE   7
`define POS_TXDONE   1
`define POS_TXEMPTY  2
`define POS_RXEN     0
`define POS_TXEN     1
`define POS_STOP2    3
// sampling select codes
`define SEL_NORMAL   2'h0
`define SEL_DOUBLE   2'h1
`define SEL_LIN      2'h2
// reset values
`define RST_BAUD     16'h0000
`define RST_CSIZE    3'h3
// samples per bit and first voting sample
`define SPB_NORMAL   5'h10
`define SPB_DOUBLE   5'h08
`define VOTE_NORMAL  5'h08
`define VOTE_DOUBLE  5'h04
`endif

// *** design/uart_dp_pkg.sv ***
`default_nettype none
package uart_dp_pkg;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_HOLD} rx_state_t;
  typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} tx_state_t;
  // one receive fifo entry: flags travel with their frame
  typedef struct packed {
    logic       framing_fault_flag;
    logic       ovf;
    logic       parity_fault_flag;
    logic [8:0] data;
  } rx_entry_t;
  // apb request as seen by the slave
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } apb_req_t;
endpackage
`default_nettype wire

// *** design/uart_datapath.sv ***
// Contract
// - load holding buffer into shifter when idle or right after last stop bit
// - set tx done when frame sent and holding buffer empty
// - characters under eight bits ignore upper written bits
// - tx disable waits until shifter and holding buffer are empty
// - disabled transmitter releases the pin to input
// - receiver shifts bits through the first stop bit, ignores a second
// - completed frame goes to receive buffer and sets rx done
// - unused upper receive bits read as zero
// - low byte read advances fifo; read high byte first
// - framing, overrun, parity flags stored per frame, shown in high byte
// - parity check compares computed and received parity bit
// - lin mode checks protected identifier parity equations
// - rx disable is immediate, flushes buffer and current reception
// - oversample sixteen times, or eight in double rate
// - start bit majority vote on samples 8-10 or 4-6
// - each bit decided by majority of three centre samples
// - low first stop bit sets framing fault
// - next start edge accepted after stop vote; later in double rate
// - double rate selected in second control register halves samples
// - frame: low start, 5-9 data, optional parity, 1-2 high stop
// - even parity bit is one for odd ones count; odd inverted
`default_nettype none
`include "uart_dp_params.svh"
module uart_datapath #(
  parameter int RX_DEPTH = 2
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxd_in,
  output logic             txd_out,
  output logic             txd_oe
);
  localparam int PW = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;
  // refuse depths the fifo pointers cannot serve
  if (RX_DEPTH < 1 || RX_DEPTH > 16) begin : g_depth_check
    $error("RX_DEPTH out of range");
  end

  typedef struct packed {
    logic                      rdy;
    logic [31:0]               rdata;
    logic                      err;
    logic [1:0]                rxs;
    logic                      line_prev;
    logic                      rx_en;
    logic                      tx_en;
    logic [1:0]                sel;
    logic [2:0]                csize;
    logic [1:0]                pmode;
    logic                      stop2;
    logic [15:0]               baud;
    logic [15:0]               div;
    uart_dp_pkg::rx_state_t    rst;
    logic [4:0]                rsc;
    logic [3:0]                ridx;
    logic [2:0]                votes;
    logic [8:0]                rsr;
    logic                      rpar;
    uart_dp_pkg::rx_entry_t [RX_DEPTH-1:0] fifo;
    logic [PW:0]               cnt;
    logic [PW-1:0]             head;
    uart_dp_pkg::tx_state_t    tst;
    logic [4:0]                tsc;
    logic [3:0]                tidx;
    logic [3:0]                tlen;
    logic [12:0]               tframe;
    logic                      hold_valid;
    logic [8:0]                hold;
    logic                      hi9;
    logic                      tx_done;
  } state_t;

  state_t st;
  state_t next_st;
  logic [1:0] rst_sync;
  logic       rst_n;

  // reset released through two flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) rst_sync <= 2'h0;
    else rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  uart_dp_pkg::apb_req_t req;
  logic        tick;
  logic        dbl;
  logic [4:0]  spb;
  logic [4:0]  vlo;
  logic [4:0]  rnsc;
  logic [3:0]  dbits;
  logic        par_on;
  logic        rline;
  logic [2:0]  nvotes;
  logic        maj;
  logic        vote_end;
  logic        done_xfer;
  logic        pop;
  logic        push;
  logic        tx_end;
  logic        tx_load;
  logic [PW-1:0] tail;
  uart_dp_pkg::rx_entry_t head_e;
  uart_dp_pkg::rx_entry_t new_e;
  logic [8:0]  dmask;
  logic [8:0]  ld;
  logic [12:0] fr;

  assign req = '{psel, penable, pwrite, paddr, pwdata};
  assign dbl = (st.sel == `SEL_DOUBLE);
  assign spb = dbl ? `SPB_DOUBLE : `SPB_NORMAL;
  assign vlo = dbl ? `VOTE_DOUBLE : `VOTE_NORMAL;
  assign dbits = (st.csize > 3'h4) ? 4'h8 : 4'(st.csize) + 4'h5;
  assign par_on = st.pmode[1];
  assign rline = st.rxs[1];
  assign tick = (st.div == 16'h0000);
  assign rnsc = (st.rsc == spb) ? 5'h01 : st.rsc + 5'h01;
  assign nvotes = {st.votes[1:0], rline};
  // two of three samples decide the level
  assign maj = (nvotes[0] & nvotes[1]) | (nvotes[0] & nvotes[2]) |
               (nvotes[1] & nvotes[2]);
  assign vote_end = tick && (rnsc == vlo + 5'h02);
  assign done_xfer = req.sel && req.enable && st.rdy;
  assign head_e = st.fifo[st.head];
  assign pop = done_xfer && !req.write && req.addr == `OFS_RX_LOW &&
               st.cnt != '0;
  assign tail = PW'((32'(st.head) + 32'(st.cnt)) % RX_DEPTH);
  assign push = st.rx_en && st.rst == uart_dp_pkg::RX_DATA && vote_end &&
                st.ridx == dbits + 4'(par_on);
  assign tx_end = st.tst == uart_dp_pkg::TX_SHIFT && tick &&
                  st.tsc == spb - 5'h01 && st.tidx == st.tlen - 4'h1;
  assign tx_load = st.hold_valid &&
                   (st.tst == uart_dp_pkg::TX_IDLE || tx_end);
  assign dmask = 9'(10'h3ff >> (4'ha - dbits)); // dbits low ones

  // received frame with its parity and framing result
  always_comb begin
    new_e = '0;
    new_e.data = st.rsr & dmask;
    new_e.framing_fault_flag = !maj;
    if (par_on)
      new_e.parity_fault_flag = (^new_e.data) ^ st.rpar ^ st.pmode[0];
    else if (st.sel == `SEL_LIN && dbits == 4'h8)
      new_e.parity_fault_flag =
        (st.rsr[6] != (st.rsr[0] ^ st.rsr[1] ^ st.rsr[2] ^ st.rsr[4])) ||
        (st.rsr[7] != !(st.rsr[1] ^ st.rsr[3] ^ st.rsr[4] ^ st.rsr[5]));
  end

  // transmit frame: start, data, parity, stop bits all high above
  always_comb begin
    ld = st.hold & dmask;
    fr = 13'h1fff;
    fr[0] = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < dbits) fr[i+1] = ld[i];
    end
    if (par_on) fr[dbits+4'h1] = (^ld) ^ st.pmode[0];
  end

  always_comb begin
    next_st = st;
    next_st.rxs = {st.rxs[0], rxd_in};
    next_st.div = tick ? st.baud : st.div - 16'h0001;
    // apb: one wait cycle, data latched, effects at completion
    next_st.rdy = req.sel && req.enable && !st.rdy;
    if (req.sel && req.enable && !st.rdy) begin
      next_st.err = 1'b0;
      next_st.rdata = '0;
      if (req.addr == `OFS_RX_LOW) begin
        next_st.rdata[7:0] = head_e.data[7:0];
      end else if (req.addr == `OFS_RX_HIGH) begin
        next_st.rdata[`POS_DATA8] = head_e.data[8];
        next_st.rdata[`POS_PARITY_FAULT_FLAG] = head_e.parity_fault_flag;
        next_st.rdata[`POS_OVF] = head_e.ovf;
        next_st.rdata[`POS_FRAMING_FAULT_FLAG] = head_e.framing_fault_flag;
        next_st.rdata[`POS_RXDONE] = st.cnt != '0;
      end else if (req.addr == `OFS_TX_HIGH) begin
        next_st.rdata[0] = st.hi9;
      end else if (req.addr == `OFS_STATUS) begin
        next_st.rdata[`POS_RXDONE] = st.cnt != '0;
        next_st.rdata[`POS_TXDONE] = st.tx_done;
        next_st.rdata[`POS_TXEMPTY] = !st.hold_valid;
      end else if (req.addr == `OFS_CTRL_A) begin
        next_st.rdata[`POS_RXEN] = st.rx_en;
        next_st.rdata[`POS_TXEN] = st.tx_en;
      end else if (req.addr == `OFS_CTRL_B) begin
        next_st.rdata[1:0] = st.sel;
      end else if (req.addr == `OFS_CTRL_C) begin
        next_st.rdata[`POS_STOP2] = st.stop2;
        next_st.rdata[2:0] = st.csize;
        next_st.rdata[5:4] = st.pmode;
      end else if (req.addr == `OFS_BAUD) begin
        next_st.rdata[15:0] = st.baud;
      end else if (req.addr != `OFS_TX_LOW) begin
        next_st.err = 1'b1;
      end
    end
    if (done_xfer && req.write && !st.err) begin
      if (req.addr == `OFS_CTRL_A) begin
        next_st.rx_en = req.wdata[`POS_RXEN];
        next_st.tx_en = req.wdata[`POS_TXEN];
      end else if (req.addr == `OFS_CTRL_B) begin
        next_st.sel = req.wdata[1:0];
      end else if (req.addr == `OFS_CTRL_C) begin
        next_st.csize = req.wdata[2:0];
        next_st.pmode = req.wdata[5:4];
        next_st.stop2 = req.wdata[`POS_STOP2];
      end else if (req.addr == `OFS_BAUD) begin
        next_st.baud = req.wdata[15:0];
      end else if (req.addr == `OFS_TX_HIGH) begin
        next_st.hi9 = req.wdata[0];
      end else if (req.addr == `OFS_STATUS &&
                   req.wdata[`POS_TXDONE]) begin
        next_st.tx_done = 1'b0;
      end else if (req.addr == `OFS_TX_LOW && st.tx_en &&
                   !st.hold_valid) begin
        // low byte completes the value
        next_st.hold = {st.hi9, req.wdata[7:0]};
        next_st.hold_valid = 1'b1;
      end
    end
    // transmitter
    if (st.tst == uart_dp_pkg::TX_SHIFT && tick) begin
      next_st.tsc = st.tsc + 5'h01;
      if (st.tsc == spb - 5'h01) begin
        next_st.tsc = 5'h00;
        next_st.tidx = st.tidx + 4'h1;
      end
    end
    if (tx_end) begin
      next_st.tst = uart_dp_pkg::TX_IDLE;
      if (!st.hold_valid) next_st.tx_done = 1'b1;
    end
    if (tx_load) begin
      next_st.tst = uart_dp_pkg::TX_SHIFT;
      next_st.tframe = fr;
      next_st.tlen = 4'h2 + dbits + 4'(par_on) + 4'(st.stop2);
      next_st.tidx = 4'h0;
      next_st.tsc = 5'h00;
      next_st.hold_valid = 1'b0;
    end
    // receiver
    if (tick) begin
      case (st.rst)
        uart_dp_pkg::RX_IDLE: begin
          next_st.line_prev = rline;
          if (st.line_prev && !rline) begin
            next_st.rst = uart_dp_pkg::RX_START;
            next_st.rsc = 5'h01;
            next_st.rsr = '0;
          end
        end
        uart_dp_pkg::RX_START: begin
          next_st.rsc = rnsc;
          if (rnsc >= vlo) next_st.votes = nvotes;
          if (vote_end) begin
            next_st.ridx = 4'h0;
            next_st.line_prev = 1'b1;
            next_st.rst = maj ? uart_dp_pkg::RX_IDLE
                              : uart_dp_pkg::RX_DATA;
          end
        end
        uart_dp_pkg::RX_DATA: begin
          next_st.rsc = rnsc;
          if (rnsc >= vlo) next_st.votes = nvotes;
          if (vote_end) begin
            next_st.ridx = st.ridx + 4'h1;
            if (st.ridx < dbits) next_st.rsr[st.ridx] = maj;
            else if (st.ridx == dbits && par_on) next_st.rpar = maj;
            else begin
              // second stop bit never sampled
              next_st.line_prev = maj;
              next_st.rst = dbl ? uart_dp_pkg::RX_HOLD
                                : uart_dp_pkg::RX_IDLE;
            end
          end
        end
        default: begin
          next_st.rsc = rnsc;
          if (rnsc == spb) next_st.rst = uart_dp_pkg::RX_IDLE;
        end
      endcase
    end
    if (pop) begin
      next_st.head = PW'((32'(st.head) + 1) % RX_DEPTH);
      next_st.cnt = st.cnt - (PW+1)'(1);
    end
    if (push) begin
      if (st.cnt == (PW+1)'(RX_DEPTH) && !pop) begin
        next_st.fifo[PW'((32'(tail) + RX_DEPTH - 1) % RX_DEPTH)].ovf =
          1'b1;
      end else begin
        next_st.fifo[tail] = new_e;
        next_st.cnt = next_st.cnt + (PW+1)'(1);
      end
    end
    if (!st.rx_en) begin
      next_st.cnt = '0;
      next_st.rst = uart_dp_pkg::RX_IDLE;
      next_st.line_prev = 1'b0;
    end
  end

  // all state registered together
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.csize <= `RST_CSIZE;
      st.baud <= `RST_BAUD;
      st.rxs <= 2'h3;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.rdata;
  assign pready = st.rdy;
  assign pslverr = st.rdy & st.err;
  assign txd_out = (st.tst == uart_dp_pkg::TX_IDLE) | st.tframe[st.tidx];
  assign txd_oe = st.tx_en | st.hold_valid |
                  (st.tst == uart_dp_pkg::TX_SHIFT);

  a_tx_load_idle: assert property (
    @(posedge clk) disable iff (!rst_n)
    st.hold_valid && st.tst == uart_dp_pkg::TX_IDLE
    |=> st.tst == uart_dp_pkg::TX_SHIFT && !st.hold_valid)
    else $error("holding value not loaded");
  a_tx_done_set: assert property (
    @(posedge clk) disable iff (!rst_n)
    tx_end && !st.hold_valid |=> st.tx_done)
    else $error("tx done not set");
  a_tx_busy_drive: assert property (
    @(posedge clk) disable iff (!rst_n)
    st.tst == uart_dp_pkg::TX_SHIFT && !tx_end
    |=> st.tst == uart_dp_pkg::TX_SHIFT && txd_oe)
    else $error("frame cut short");
  a_pin_release: assert property (
    @(posedge clk) disable iff (!rst_n)
    !st.tx_en && !st.hold_valid && st.tst == uart_dp_pkg::TX_IDLE
    |-> !txd_oe)
    else $error("pin still driven");
  a_start_bit_low: assert property (
    @(posedge clk) disable iff (!rst_n)
    st.tst == uart_dp_pkg::TX_SHIFT && st.tidx == 4'h0 |-> !txd_out)
    else $error("start bit not low");
  a_stop_bit_high: assert property (
    @(posedge clk) disable iff (!rst_n)
    st.tst == uart_dp_pkg::TX_SHIFT && st.tidx == st.tlen - 4'h1
    |-> txd_out)
    else $error("stop bit not high");
  a_rx_flush_now: assert property (
    @(posedge clk) disable iff (!rst_n)
    !st.rx_en |=> st.cnt == '0 && st.rst == uart_dp_pkg::RX_IDLE)
    else $error("receiver not flushed");
  a_start_reject: assert property (
    @(posedge clk) disable iff (!rst_n)
    st.rx_en && st.rst == uart_dp_pkg::RX_START && vote_end && maj
    |=> st.rst == uart_dp_pkg::RX_IDLE)
    else $error("noise start accepted");
  a_rx_push_done: assert property (
    @(posedge clk) disable iff (!rst_n)
    push && !pop |=> st.cnt != '0)
    else $error("frame not buffered");
  a_framing_fault_flag_stored: assert property (
    @(posedge clk) disable iff (!rst_n)
    push && st.cnt == '0 && !maj |=> head_e.framing_fault_flag)
    else $error("framing fault lost");
endmodule
`default_nettype wire

// *** tb/uart_remote_model.sv ***
`default_nettype none
module uart_remote_model (
  input  wire logic       clk,
  input  wire logic       tx_line,
  input  wire logic [4:0] spb,
  input  wire logic [3:0] nbits,
  input  wire logic       par_en,
  output logic            rxd
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [10:0] got[$];

  // line rests high between frames
  initial rxd = 1'b1;

  // one bit time on the line
  task automatic bit_out(input logic v);
    rxd <= v;
    repeat (spb) @(posedge clk);
  endtask

  // start, data lsb first, optional parity, stop, one idle bit
  task automatic send(input logic [8:0] d, input logic pb, input logic sp);
    bit_out(1'b0);
    for (int i = 0; i < nbits; i++) bit_out(d[i]);
    if (par_en) bit_out(pb);
    bit_out(sp);
    bit_out(1'b1);
  endtask

  // short low pulse, n samples long
  task automatic glitch(input int n);
    rxd <= 1'b0;
    repeat (n) @(posedge clk);
    bit_out(1'b1);
  endtask

  // capture the block's frames at bit centres, stop bit included
  always begin
    logic [10:0] v;
    @(negedge tx_line);
    v = '0;
    repeat (spb >> 1) @(posedge clk);
    for (int i = 0; i <= nbits + par_en; i++) begin
      repeat (spb) @(posedge clk);
      v[i] = tx_line;
    end
    got.push_back(v);
  end
endmodule
`default_nettype wire

// *** tb/uart_datapath_tb.sv ***
`default_nettype none
`include "uart_dp_params.svh"
module uart_datapath_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk;
  logic        resetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdv;
  logic        pready, pslverr, errv, txd_out, txd_oe, rxd_in, line;
  logic [4:0]  spb = 5'h10;
  logic [3:0]  nbits = 4'h8;
  logic        par_en = 1'b0;
  int          failures = 0;
  int          n_compared = 0;
  int          cyc = 0;

  // released tx pin is pulled up
  assign line = txd_oe ? txd_out : 1'b1;

  uart_datapath #(.RX_DEPTH(2)) uart_datapath_i (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd_in(rxd_in),
    .txd_out(txd_out), .txd_oe(txd_oe));

  uart_remote_model uart_remote_model_i (
    .clk(clk), .tx_line(line), .spb(spb), .nbits(nbits),
    .par_en(par_en), .rxd(rxd_in));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 50000) begin
      chk("timeout", 32'h0, 32'h1);
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("compared %0d failed %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask

  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wait_st(input int b);
    do begin
      rd(`OFS_STATUS);
    end while (rdv[b] !== 1'b1);
  endtask

  task automatic cfg(input logic [7:0] c, input logic [3:0] nb,
                     input logic pe);
    wr(`OFS_CTRL_C, {24'h0, c});
    nbits  <= nb;
    par_en <= pe;
  endtask

  task automatic tx_put(input logic [7:0] d);
    wait_st(2);
    wr(`OFS_TX_LOW, {24'h0, d});
  endtask

  task automatic tx_frame(input logic [10:0] e);
    logic [10:0] g;
    for (int k = 0; k < 3000 && uart_remote_model_i.got.size() == 0; k++)
      @(posedge clk);
    g = uart_remote_model_i.got.pop_front();
    chk("tx frame", {21'h0, e}, {21'h0, g});
  endtask

  task automatic tx_idle();
    wait_st(1);
    wr(`OFS_STATUS, 32'h2);
  endtask

  task automatic rd_pair(input logic [7:0] hi, input logic [7:0] lo);
    rd(`OFS_RX_HIGH);
    chk("rx high", {24'h0, hi}, rdv);
    rd(`OFS_RX_LOW);
    chk("rx low", {24'h0, lo}, rdv);
  endtask

  task automatic rx_one(input logic [8:0] d, input logic pb, input logic sp,
                        input logic [7:0] hi, input logic [7:0] lo);
    uart_remote_model_i.send(d, pb, sp);
    wait_st(`POS_RXDONE);
    rd_pair(hi, lo);
  endtask

  function automatic logic [7:0] pid(input logic [5:0] i);
    return {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4], i};
  endfunction

  task automatic t_tx();
    cfg(8'h03, 4'h8, 1'b0);
    wr(`OFS_CTRL_A, 32'h3);
    tx_put(8'ha5);
    tx_put(8'h3c);
    chk("tx oe on", 32'h1, {31'h0, txd_oe});
    wr(`OFS_CTRL_A, 32'h1);
    tx_frame(11'h1a5);
    tx_frame(11'h13c);
    wait_st(1);
    chk("tx done", 32'h1, {31'h0, rdv[1]});
    chk("tx oe off", 32'h0, {31'h0, txd_oe});
    wr(`OFS_STATUS, 32'h2);
    rd(`OFS_STATUS);
    chk("tx done clr", 32'h0, {31'h0, rdv[1]});
    $display("end tx");
  endtask

  task automatic t_txsize();
    wr(`OFS_CTRL_A, 32'h2);
    cfg(8'h00, 4'h5, 1'b0);
    tx_put(8'hff);
    tx_frame(11'h03f);
    tx_idle();
    cfg(8'h04, 4'h9, 1'b0);
    wr(`OFS_TX_HIGH, 32'h1);
    tx_put(8'h55);
    tx_frame(11'h355);
    tx_idle();
    cfg(8'h22, 4'h7, 1'b1);
    tx_put(8'h07);
    tx_frame(11'h187);
    tx_idle();
    tx_put(8'h87);
    tx_frame(11'h187);
    tx_idle();
    cfg(8'h32, 4'h7, 1'b1);
    tx_put(8'h07);
    tx_frame(11'h107);
    tx_idle();
    $display("end tx sizes");
  endtask

  task automatic t_rx();
    wr(`OFS_CTRL_A, 32'h1);
    cfg(8'h23, 4'h8, 1'b1);
    rx_one(9'h096, 1'b0, 1'b1, 8'h80, 8'h96);
    rx_one(9'h096, 1'b1, 1'b1, 8'h82, 8'h96);
    rx_one(9'h0f0, 1'b0, 1'b0, 8'h88, 8'hf0);
    cfg(8'h00, 4'h5, 1'b0);
    rx_one(9'h1ff, 1'b0, 1'b1, 8'h80, 8'h1f);
    cfg(8'h04, 4'h9, 1'b0);
    rx_one(9'h1a5, 1'b0, 1'b1, 8'h81, 8'ha5);
    rd(`OFS_STATUS);
    chk("rx empty", 32'h0, {31'h0, rdv[`POS_RXDONE]});
    $display("end rx");
  endtask

  task automatic t_ovf();
    cfg(8'h03, 4'h8, 1'b0);
    uart_remote_model_i.send(9'h011, 1'b0, 1'b1);
    uart_remote_model_i.send(9'h022, 1'b0, 1'b1);
    uart_remote_model_i.send(9'h033, 1'b0, 1'b1);
    rd_pair(8'h80, 8'h11);
    rd_pair(8'h84, 8'h22);
    rd(`OFS_STATUS);
    chk("ovf empty", 32'h0, {31'h0, rdv[`POS_RXDONE]});
    $display("end overrun");
  endtask

  task automatic t_flush();
    uart_remote_model_i.send(9'h044, 1'b0, 1'b1);
    wait_st(`POS_RXDONE);
    fork
      uart_remote_model_i.send(9'h0ff, 1'b0, 1'b1);
    join_none
    repeat (40) @(posedge clk);
    wr(`OFS_CTRL_A, 32'h0);
    wr(`OFS_CTRL_A, 32'h1);
    wait fork;
    rd(`OFS_STATUS);
    chk("flushed", 32'h0, {31'h0, rdv[`POS_RXDONE]});
    uart_remote_model_i.glitch(8);
    rd(`OFS_STATUS);
    chk("spike", 32'h0, {31'h0, rdv[`POS_RXDONE]});
    uart_remote_model_i.glitch(9);
    wait_st(`POS_RXDONE);
    rd_pair(8'h80, 8'hff);
    $display("end flush");
  endtask

  task automatic t_modes();
    wr(`OFS_CTRL_B, {30'h0, `SEL_DOUBLE});
    rd(`OFS_CTRL_B);
    chk("ctrl_b", 32'h1, rdv);
    spb <= 5'h08;
    @(posedge clk); // let the model see the new bit length
    rx_one(9'h05a, 1'b0, 1'b1, 8'h80, 8'h5a);
    spb <= 5'h10;
    wr(`OFS_CTRL_B, {30'h0, `SEL_LIN});
    rx_one({1'b0, pid(6'h2b)}, 1'b0, 1'b1, 8'h80, pid(6'h2b));
    rx_one({1'b0, pid(6'h2b) ^ 8'h40}, 1'b0, 1'b1, 8'h82,
           pid(6'h2b) ^ 8'h40);
    rx_one({1'b0, pid(6'h11) ^ 8'h80}, 1'b0, 1'b1, 8'h82,
           pid(6'h11) ^ 8'h80);
    rd(12'h030);
    chk("unmapped", 32'h1, {31'h0, errv});
    $display("end modes");
  endtask

  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    t_tx();
    t_txsize();
    t_rx();
    t_ovf();
    t_flush();
    t_modes();
    give_verdict();
  end
endmodule
`default_nettype wire
